/* apm_regs.svh */
// offsets, field positions, reset values and timing counts of the alarm manager
`ifndef APM_REGS_SVH
`define APM_REGS_SVH
`define APM_CLK_HZ              250000000
`define APM_SAMPLE_PERIOD_S     226
`define APM_SAMPLE_CYCLES       (64'(`APM_SAMPLE_PERIOD_S) * 64'(`APM_CLK_HZ))
`define APM_HOUR_S              3600
`define APM_HOUR_SLOTS          16
`define APM_SECOND_CYCLES       `APM_CLK_HZ
`define APM_ADDR_CFG            4'h0
`define APM_ADDR_LIMITS         4'h1
`define APM_ADDR_TIMERS         4'h2
`define APM_ADDR_FREEZE         4'h3
`define APM_ADDR_STATUS         4'h4
`define APM_ADDR_CODE           4'h5
`define APM_CFG_SEPARATE        0
`define APM_CFG_ROLE_LSB        1
`define APM_CFG_ROLE_W          4
`define APM_ROLE_ANTI_FREEZE    4'h1
`define APM_PROBE_MIN           16'shffce
`define APM_PROBE_MAX           16'sh0064
`define APM_LIMIT_RST           8'h03
`define APM_CODE_NONE           8'hff
`define APM_NUM_ALARMS          8
`endif

/* apm_pkg.sv */
// types of the alarm manager
package apm_pkg;
  typedef struct packed {
    logic comp1;
    logic comp_c1;
    logic comp_c2;
    logic fan_c1;
    logic all_loads;
  } apm_loads_t;
  typedef struct packed {
    logic remote_off;
    logic hp_c1;
    logic lp_c1;
    logic therm_comp1;
    logic therm_fan_c1;
  } apm_din_t;
  typedef struct packed {
    logic        probe2_analog;
    logic        probe2_fault;
    logic signed [15:0] probe2_value;
    logic        probe3_analog;
    logic        probe3_fault;
  } apm_probe_t;
  typedef struct packed {
    logic comp_start_c1;
    logic valve_rev_c1;
    logic comp1_start;
    logic unit_on;
    logic heat_start;
    logic onoff_release;
  } apm_event_t;
  typedef enum logic [1:0] {
    APM_IDLE   = 2'b00,
    APM_AUTO   = 2'b01,
    APM_MANUAL = 2'b10
  } apm_state_t;
endpackage

/* apm_alarm_manager.sv */
// alarm and protection manager: alarm inputs, timers, event counts, load shutdown
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "apm_regs.svh"
// Overview of operation
// - any active alarm switches off its loads; the lowest-numbered active alarm shows its code
// - alarm code is E plus two decimal digits naming the alarm type
// - remote-off input raises code 00 and stops every load
// - circuit 1 high pressure raises code 01, stops circuit 1 compressors
// - circuit 1 low pressure raises 02, stops compressors; fans too if separate
// - code 02 auto-clears below its hourly event limit, then manual reset
// - code 02 ignored while low-pressure bypass timer runs after start or reversal
// - compressor 1 thermal raises code 03, stops compressor 1 only
// - code 03 auto until its event limit, manual after; bypassed after start
// - fan thermal raises 04, stops circuit 1; combined also stops circuit 2 compressors
// - code 04 auto-resets until the fan-thermal event limit, then manual
// - code 05 evaluated only when probe two role selector is anti-freeze
// - code 05 sets below threshold, clears above threshold plus hysteresis
// - code 05 auto-resets until the anti-freeze event limit, then manual
// - code 05 suppressed while anti-freeze bypass timer runs after on or heating
// - probe two fault or outside -50..100 raises code 06, stops all
// - probe three fault raises code 07, stops all loads
// - alarms sampled once per 226 s; one event per period at most
// - manual-reset alarm holds loads off until on-off press and release
module apm_alarm_manager #(
  parameter longint SAMPLE_CYCLES = `APM_SAMPLE_CYCLES,
  parameter int     SECOND_CYCLES = `APM_SECOND_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire apm_pkg::apm_din_t   alarm_pins,
  input  wire apm_pkg::apm_probe_t probes,
  input  wire apm_pkg::apm_event_t events,
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  output apm_pkg::apm_loads_t    loads_off,
  output logic [7:0]             display_code,
  output logic                   display_valid
);
  localparam int N = `APM_NUM_ALARMS;

  // pins come from outside: two flops before use
  apm_pkg::apm_din_t pin_meta;
  apm_pkg::apm_din_t pin_sync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= alarm_pins;
      pin_sync <= pin_meta;
    end
  end

  // configuration registers
  logic        separate_cond;
  logic [3:0]  probe_two_role_selector;
  logic [7:0]  low_pressure_event_limit;
  logic [7:0]  compressor_thermal_event_limit;
  logic [7:0]  fan_thermal_event_limit;
  logic [7:0]  anti_freeze_event_limit;
  logic [7:0]  low_pressure_bypass_timer;
  logic [7:0]  thermal_bypass_timer;
  logic [7:0]  anti_freeze_bypass_timer;
  logic signed [15:0] anti_freeze_threshold;
  logic [7:0]  anti_freeze_hysteresis;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      separate_cond                  <= 1'b0;
      probe_two_role_selector        <= 4'h0;
      low_pressure_event_limit       <= `APM_LIMIT_RST;
      compressor_thermal_event_limit <= `APM_LIMIT_RST;
      fan_thermal_event_limit        <= `APM_LIMIT_RST;
      anti_freeze_event_limit        <= `APM_LIMIT_RST;
      low_pressure_bypass_timer      <= 8'h00;
      thermal_bypass_timer           <= 8'h00;
      anti_freeze_bypass_timer       <= 8'h00;
      anti_freeze_threshold          <= 16'sh0000;
      anti_freeze_hysteresis         <= 8'h00;
    end else if (wr) begin
      case (addr)
        `APM_ADDR_CFG: begin
          separate_cond           <= wdata[`APM_CFG_SEPARATE];
          probe_two_role_selector <= wdata[`APM_CFG_ROLE_LSB +: `APM_CFG_ROLE_W];
        end
        `APM_ADDR_LIMITS: begin
          low_pressure_event_limit       <= wdata[7:0];
          compressor_thermal_event_limit <= wdata[15:8];
          fan_thermal_event_limit        <= wdata[23:16];
          anti_freeze_event_limit        <= wdata[31:24];
        end
        `APM_ADDR_TIMERS: begin
          low_pressure_bypass_timer <= wdata[7:0];
          thermal_bypass_timer      <= wdata[15:8];
          anti_freeze_bypass_timer  <= wdata[23:16];
        end
        `APM_ADDR_FREEZE: begin
          anti_freeze_threshold  <= wdata[15:0];
          anti_freeze_hysteresis <= wdata[23:16];
        end
        default: begin
        end
      endcase
    end
  end

  // one-second tick and sampling instant
  logic [31:0] sec_cnt;
  logic [39:0] samp_cnt;
  logic        sec_tick;
  logic        samp_tick;
  assign sec_tick  = (sec_cnt == 32'(SECOND_CYCLES - 1));
  assign samp_tick = (samp_cnt == 40'(SAMPLE_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 32'h0;
    end else begin
      sec_cnt <= sec_tick ? 32'h0 : sec_cnt + 32'h1;
    end
  end
  // free-running: alarms between two ticks are seen only at the next tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt <= 40'h0;
    end else begin
      samp_cnt <= samp_tick ? 40'h0 : samp_cnt + 40'h1;
    end
  end

  // bypass timers in seconds; a restart event reloads them
  logic [7:0] lp_byp;
  logic [7:0] th_byp;
  logic [7:0] af_byp;
  // a restart within a running mask lengthens it: the reload always wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_byp <= 8'h0;
    end else if (events.comp_start_c1 || events.valve_rev_c1) begin
      lp_byp <= low_pressure_bypass_timer;
    end else if (sec_tick && lp_byp != 8'h0) begin
      lp_byp <= lp_byp - 8'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      th_byp <= 8'h0;
    end else if (events.comp1_start) begin
      th_byp <= thermal_bypass_timer;
    end else if (sec_tick && th_byp != 8'h0) begin
      th_byp <= th_byp - 8'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      af_byp <= 8'h0;
    end else if (events.unit_on || events.heat_start) begin
      af_byp <= anti_freeze_bypass_timer;
    end else if (sec_tick && af_byp != 8'h0) begin
      af_byp <= af_byp - 8'h1;
    end
  end

  // anti-freeze hysteresis latch
  logic freeze_cond;
  logic signed [16:0] freeze_release;
  // one extra bit so threshold plus hysteresis cannot wrap
  assign freeze_release = 17'(anti_freeze_threshold)
                          + 17'(signed'({1'b0, anti_freeze_hysteresis}));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_cond <= 1'b0;
    end else if (probes.probe2_value < anti_freeze_threshold) begin
      freeze_cond <= 1'b1;
    end else if (17'(probes.probe2_value) > freeze_release) begin
      freeze_cond <= 1'b0;
    end
  end

  // raw conditions, index equals alarm number
  logic [N-1:0] cond;
  logic [N-1:0] counted;
  logic [7:0]   limit [N];
  logic         probe2_out;
  assign probe2_out = probes.probe2_value < `APM_PROBE_MIN || probes.probe2_value > `APM_PROBE_MAX;
  always_comb begin
    cond    = '0;
    cond[0] = pin_sync.remote_off;
    cond[1] = pin_sync.hp_c1;
    cond[2] = pin_sync.lp_c1 && lp_byp == 8'h0;
    cond[3] = pin_sync.therm_comp1 && th_byp == 8'h0;
    cond[4] = pin_sync.therm_fan_c1;
    cond[5] = freeze_cond && af_byp == 8'h0
              && probe_two_role_selector == `APM_ROLE_ANTI_FREEZE;
    cond[6] = probes.probe2_analog && (probes.probe2_fault || probe2_out);
    cond[7] = probes.probe3_analog && probes.probe3_fault;
  end
  assign counted = 8'h3c;
  assign limit[0] = 8'h0;
  assign limit[1] = 8'h0;
  assign limit[2] = low_pressure_event_limit;
  assign limit[3] = compressor_thermal_event_limit;
  assign limit[4] = fan_thermal_event_limit;
  assign limit[5] = anti_freeze_event_limit;
  assign limit[6] = 8'h0;
  assign limit[7] = 8'h0;

  // per-alarm state and hourly event history, one slot per sampling period
  apm_pkg::apm_state_t st [N];
  logic [N-1:0] active;
  localparam int SW = `APM_HOUR_SLOTS;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_alarm
      logic [SW-1:0] hist;
      logic [4:0]    cnt;
      always_comb begin
        cnt = 5'h0;
        for (int i = 0; i < SW; i++) cnt = cnt + 5'(hist[i]);
      end
      // one bit per 226 s period: repeated triggers in a period count once
      // only a fresh trigger is logged, so a standing alarm is not counted twice
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          hist <= '0;
        end else if (samp_tick) begin
          hist <= {hist[SW-2:0], cond[g] && st[g] == apm_pkg::APM_IDLE};
        end
      end
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          st[g] <= apm_pkg::APM_IDLE;
        end else begin
          case (st[g])
            apm_pkg::APM_IDLE: begin
              if (samp_tick && cond[g]) begin
                if (counted[g] && ({3'h0, cnt} + 8'h1) >= limit[g]) begin
                  st[g] <= apm_pkg::APM_MANUAL;
                end else if (counted[g]) begin
                  st[g] <= apm_pkg::APM_AUTO;
                end else if (g == 0 || g >= 6) begin
                  st[g] <= apm_pkg::APM_AUTO;
                end else begin
                  st[g] <= apm_pkg::APM_MANUAL;
                end
              end
            end
            apm_pkg::APM_AUTO: begin
              if (samp_tick && !cond[g]) begin
                st[g] <= apm_pkg::APM_IDLE;
              end
            end
            apm_pkg::APM_MANUAL: begin
              // a key press while the fault persists is ignored, loads stay off
              if (events.onoff_release && !cond[g]) begin
                st[g] <= apm_pkg::APM_IDLE;
              end
            end
            default: begin
              st[g] <= apm_pkg::APM_IDLE;
            end
          endcase
        end
      end
      assign active[g] = st[g] != apm_pkg::APM_IDLE;
    end
  endgenerate

  // load shutdown and display, registered
  apm_pkg::apm_loads_t next_loads;
  always_comb begin
    next_loads           = '0;
    next_loads.all_loads = active[0] | active[6] | active[7];
    next_loads.comp_c1   = active[1] | active[2] | active[4] | active[5];
    next_loads.fan_c1    = (active[2] & separate_cond) | active[4] | active[5];
    next_loads.comp1     = active[3];
    next_loads.comp_c2   = active[4] & ~separate_cond;
  end
  logic [7:0] next_code;
  always_comb begin
    next_code = `APM_CODE_NONE;
    for (int i = N - 1; i >= 0; i--) if (active[i]) next_code = 8'(i);
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loads_off     <= '0;
      display_code  <= `APM_CODE_NONE;
      display_valid <= 1'b0;
    end else begin
      loads_off     <= next_loads;
      display_code  <= next_code;
      display_valid <= |active;
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rdata <= 32'h0;
    else if (rd) begin
      case (addr)
        `APM_ADDR_CFG:    rdata <= {27'h0, probe_two_role_selector, separate_cond};
        `APM_ADDR_LIMITS: rdata <= {anti_freeze_event_limit, fan_thermal_event_limit,
                                    compressor_thermal_event_limit, low_pressure_event_limit};
        `APM_ADDR_TIMERS: rdata <= {8'h0, anti_freeze_bypass_timer, thermal_bypass_timer,
                                    low_pressure_bypass_timer};
        `APM_ADDR_FREEZE: rdata <= {8'h0, anti_freeze_hysteresis, anti_freeze_threshold};
        `APM_ADDR_STATUS: rdata <= {24'h0, active};
        `APM_ADDR_CODE:   rdata <= {24'h0, next_code};
        default:          rdata <= 32'h0;
      endcase
    end else rdata <= 32'h0;
  end
endmodule // apm_alarm_manager

/* apm_far_model.sv */
// far-side model: alarm contacts and probes facing the alarm manager
`timescale 1ns/100ps
module apm_far_model (
  input  wire logic                core_clk,
  input  wire apm_pkg::apm_din_t   pin_cmd,
  input  wire apm_pkg::apm_probe_t probe_cmd,
  input  wire apm_pkg::apm_loads_t loads_off,
  output apm_pkg::apm_din_t        alarm_pins,
  output apm_pkg::apm_probe_t      probes,
  output logic [4:0]               relays_on
);
  // contacts move only just after an edge, so the sampling never races
  always @(posedge core_clk) begin
    alarm_pins <= pin_cmd;
    probes <= probe_cmd;
  end
  assign relays_on = ~loads_off;
endmodule // apm_far_model

/* apm_alarm_manager_monitor.sv */
// port checker of the alarm manager
`timescale 1ns/100ps
module apm_alarm_manager_monitor (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                rd,
  input wire logic [31:0]         rdata,
  input wire apm_pkg::apm_loads_t loads_off,
  input wire logic [7:0]          display_code,
  input wire logic                display_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence shown(logic [7:0] c);
    display_valid && display_code == c;
  endsequence
  code_valid_a: assert property (display_valid == (display_code != 8'hff))
    else $error("display valid and code disagree");
  code_range_a: assert property (display_valid |-> display_code <= 8'h07)
    else $error("display code out of range");
  idle_loads_a: assert property (!display_valid |-> loads_off == 5'h00)
    else $error("load off with no alarm");
  remote_all_a: assert property (shown(8'h00) |-> loads_off.all_loads)
    else $error("remote off left loads on");
  hp_comp_a: assert property (shown(8'h01) |-> loads_off.comp_c1)
    else $error("high pressure left compressors on");
  therm_comp_a: assert property (shown(8'h03) |-> loads_off.comp1)
    else $error("thermal left compressor on");
  fan_stop_a: assert property (shown(8'h04) |-> loads_off.fan_c1 && loads_off.comp_c1)
    else $error("fan thermal left circuit on");
  freeze_stop_a: assert property (shown(8'h05) |-> loads_off.fan_c1 && loads_off.comp_c1)
    else $error("anti-freeze left circuit on");
  probe_all_a: assert property ((shown(8'h06) or shown(8'h07)) |-> loads_off.all_loads)
    else $error("probe fault left loads on");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data without read");
endmodule // apm_alarm_manager_monitor
bind apm_alarm_manager apm_alarm_manager_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .rd(rd), .rdata(rdata), .loads_off(loads_off), .display_code(display_code),
  .display_valid(display_valid));

/* tb_top.sv */
// self-checking testbench of the alarm manager
`timescale 1ns/100ps
`include "apm_regs.svh"
module tb_top;
  logic                core_clk = 1'b0;
  logic                rst_n = 1'b0;
  apm_pkg::apm_din_t   pin_cmd = '0;
  apm_pkg::apm_probe_t probe_cmd = '{1'b1, 1'b0, 16'sh0014, 1'b0, 1'b0};
  apm_pkg::apm_event_t events = '0;
  logic [3:0]          addr = 4'h0;
  logic [31:0]         wdata = 32'h0;
  logic                wr = 1'b0;
  logic                rd = 1'b0;
  apm_pkg::apm_din_t   alarm_pins;
  apm_pkg::apm_probe_t probes;
  apm_pkg::apm_loads_t loads_off;
  logic [31:0]         rdata;
  logic [7:0]          display_code;
  logic                display_valid;
  logic [31:0]         rv;
  int                  errors = 0;
  int                  check_count = 0;
  always #2 core_clk = ~core_clk;
  apm_far_model far (.core_clk(core_clk), .pin_cmd(pin_cmd), .probe_cmd(probe_cmd),
    .loads_off(loads_off), .alarm_pins(alarm_pins), .probes(probes), .relays_on());
  // short sample and second counts keep the run brief
  apm_alarm_manager #(.SAMPLE_CYCLES(20), .SECOND_CYCLES(4)) uut (.core_clk(core_clk),
    .rst_n(rst_n), .alarm_pins(alarm_pins), .probes(probes), .events(events), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .loads_off(loads_off),
    .display_code(display_code), .display_valid(display_valid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    rv = rdata;
  endtask
  task automatic pulse(input logic [5:0] e);
    @(posedge core_clk) events <= e;
    @(posedge core_clk) events <= '0;
  endtask
  task automatic pins(input logic [4:0] p);
    @(posedge core_clk) pin_cmd <= p;
  endtask
  // waits a bounded span for the code, then judges it
  task automatic wait_code(input logic [7:0] exp, input int n);
    repeat (n) begin
      @(negedge core_clk);
      if (display_code === exp) break;
    end
    check(display_code, exp);
  endtask
  task automatic hold_code(input logic [7:0] exp, input int n);
    repeat (n) @(negedge core_clk);
    check(display_code, exp);
  endtask
  task automatic t_reset();
    check({display_valid, loads_off, display_code}, 32'h0ff);
    rd_reg(4'h1);
    check(rv, 32'h03030303);
    rd_reg(4'hf);
    check(rv, 32'h0);
  endtask
  task automatic t_remote();
    pins(5'h10);
    wait_code(8'h00, 100);
    check(loads_off.all_loads, 1'b1);
    pins(5'h00);
    wait_code(8'hff, 100);
    check(loads_off, 5'h00);
  endtask
  task automatic t_hp();
    pins(5'h08);
    wait_code(8'h01, 100);
    check(loads_off.comp_c1, 1'b1);
    pins(5'h00);
    hold_code(8'h01, 80);
    rd_reg(4'h4);
    check(rv, 32'h2);
    rd_reg(4'h5);
    check(rv, 32'h1);
    pulse(6'h01);
    wait_code(8'hff, 20);
  endtask
  task automatic t_lp();
    wr_reg(4'h0, 32'h1);
    pins(5'h04);
    wait_code(8'h02, 100);
    check(loads_off, 5'h0a);
    pins(5'h00);
    wait_code(8'hff, 100);
    wr_reg(4'h2, 32'h14);
    pulse(6'h20);
    pins(5'h04);
    hold_code(8'hff, 60);
    wait_code(8'h02, 150);
    pins(5'h00);
    wait_code(8'hff, 100);
    wr_reg(4'h2, 32'h0);
    wr_reg(4'h1, 32'h03030301);
    pins(5'h04);
    wait_code(8'h02, 100);
    pins(5'h00);
    hold_code(8'h02, 80);
    pulse(6'h01);
    wait_code(8'hff, 20);
  endtask
  task automatic t_thermal();
    wr_reg(4'h0, 32'h0);
    pins(5'h02);
    wait_code(8'h03, 100);
    check(loads_off, 5'h10);
    pins(5'h00);
    wait_code(8'hff, 100);
    wr_reg(4'h2, 32'h1400);
    pulse(6'h08);
    pins(5'h02);
    hold_code(8'hff, 60);
    wait_code(8'h03, 150);
    pins(5'h00);
    wait_code(8'hff, 100);
    pins(5'h01);
    wait_code(8'h04, 100);
    check(loads_off, 5'h0e);
    pins(5'h00);
    wait_code(8'hff, 100);
  endtask
  task automatic t_freeze();
    wr_reg(4'h3, 32'h0002000a);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh0005;
    hold_code(8'hff, 60);
    wr_reg(4'h0, 32'h2);
    wait_code(8'h05, 100);
    check(loads_off, 5'h0a);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh000b;
    hold_code(8'h05, 60);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh000d;
    wait_code(8'hff, 100);
    wr_reg(4'h2, 32'h00140000);
    pulse(6'h04);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh0005;
    hold_code(8'hff, 60);
    wait_code(8'h05, 150);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh000d;
    wait_code(8'hff, 100);
  endtask
  task automatic t_probe();
    wr_reg(4'h0, 32'h0);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh0065;
    wait_code(8'h06, 100);
    check(loads_off.all_loads, 1'b1);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'sh0064;
    wait_code(8'hff, 100);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'shffcd;
    wait_code(8'h06, 100);
    @(posedge core_clk) probe_cmd.probe2_value <= 16'shffce;
    wait_code(8'hff, 100);
    @(posedge core_clk) probe_cmd.probe3_analog <= 1'b1;
    @(posedge core_clk) probe_cmd.probe3_fault <= 1'b1;
    wait_code(8'h07, 100);
    check(loads_off.all_loads, 1'b1);
    @(posedge core_clk) probe_cmd.probe3_fault <= 1'b0;
    wait_code(8'hff, 100);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_remote();
    t_hp();
    t_lp();
    t_thermal();
    t_freeze();
    t_probe();
    tally_and_finish();
  end
endmodule // tb_top
